// ==== rtl/telegram_pkg.sv ====
`default_nettype none
package telegram_pkg;

  // Framing
  localparam logic [7:0] SYNC_FIRST      = 8'h_A5;
  localparam logic [7:0] SYNC_SECOND     = 8'h_5A;
  localparam logic [7:0] REPLY_HEADER    = 8'h_8B;
  localparam logic [2:0] SEQ_COMMAND     = 3'h_5;
  localparam logic [2:0] SEQ_RADIO_TX    = 3'h_3;
  localparam logic [4:0] FRAME_LENGTH    = 5'h_0B;
  localparam logic [3:0] FRAME_LAST      = 4'h_D;
  localparam int         DATA_BYTES      = 9;

  // Host command types
  localparam logic [7:0] id_base_write_cmd          = 8'h_18;
  localparam logic [7:0] id_base_read_cmd           = 8'h_58;
  localparam logic [7:0] GAIN_SET_CMD               = 8'h_08;
  localparam logic [7:0] GAIN_READ_CMD              = 8'h_48;
  localparam logic [7:0] RESTART_CMD                = 8'h_0A;
  localparam logic [7:0] firmware_version_read_cmd  = 8'h_4B;

  // Device reply types
  localparam logic [7:0] REPLY_OK                   = 8'h_58;
  localparam logic [7:0] REPLY_FAIL                 = 8'h_19;
  localparam logic [7:0] id_base_report             = 8'h_98;
  localparam logic [7:0] receiver_gain_report       = 8'h_88;
  localparam logic [7:0] firmware_version_report    = 8'h_8C;
  localparam logic [7:0] transmit_id_reject_reply   = 8'h_22;
  localparam logic [7:0] base_out_of_bounds_reply   = 8'h_1A;

  // Syntax error field codes
  localparam logic [7:0] FIELD_SEQUENCE = 8'h_08;
  localparam logic [7:0] FIELD_LENGTH   = 8'h_09;
  localparam logic [7:0] FIELD_CHECKSUM = 8'h_0A;
  localparam logic [7:0] FIELD_TYPE     = 8'h_0B;

  // Identity range
  localparam logic [31:0] BASE_LOW        = 32'h_FF80_0000;
  localparam logic [31:0] BASE_HIGH       = 32'h_FFFF_FFFE;
  localparam logic [31:0] BASE_RESET      = 32'h_FF80_0000;
  localparam logic [31:0] UNIQUE_ID       = 32'h_0000_1234; // Arbitrary value
  localparam logic [3:0]  REWRITE_LIMIT   = 4'h_A;
  localparam logic [31:0] FW_VERSION      = 32'h_0100_0110; // Arbitrary value
  localparam logic [31:0] API_VERSION     = 32'h_0100_0000; // Arbitrary value

  // Wishbone register byte offsets
  localparam logic [4:0] OFS_STATUS  = 5'h_00;
  localparam logic [4:0] OFS_MASK    = 5'h_04;
  localparam logic [4:0] OFS_BASE    = 5'h_08;
  localparam logic [4:0] OFS_GAIN    = 5'h_0C;
  localparam logic [4:0] OFS_COUNT   = 5'h_10;

  // Event bits
  localparam int EV_REPLY   = 0;
  localparam int EV_SYNTAX  = 1;
  localparam int EV_REJECT  = 2;
  localparam int EV_RESTART = 3;
  localparam int EV_WIDTH   = 4;

  // Reply timing: 5 ms at 25 MHz
  localparam int CLK_HZ          = 25_000_000;
  localparam int REPLY_TIME_US   = 5000;
  localparam int REPLY_CYCLES    = CLK_HZ / 1_000_000 * REPLY_TIME_US;

endpackage
`default_nettype wire

// ==== rtl/frame_collector.sv ====
`timescale 1ns/100ps
`default_nettype none
module frame_collector
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Incoming byte stream
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  // Collected frame
  output logic             frameDone,
  output logic [7:0]       frameHeader,
  output logic [7:0]       frameType,
  output logic [71:0]      frameData,
  output logic             frameSumOk
);

  logic [3:0]  idx_reg, idx_next;
  logic [7:0]  sum_reg, sum_next;
  logic        done_reg, done_next;
  logic [7:0]  hdr_reg, hdr_next;
  logic [7:0]  type_reg, type_next;
  logic [71:0] data_reg, data_next;
  logic        ok_reg, ok_next;

  always_comb
  begin
    idx_next  = idx_reg;
    sum_next  = sum_reg;
    done_next = 1'b0;
    hdr_next  = hdr_reg;
    type_next = type_reg;
    data_next = data_reg;
    ok_next   = ok_reg;
    if (rxValid)
    begin
      if (idx_reg == 4'h_0)
        idx_next = (rxByte == telegram_pkg::SYNC_FIRST) ? 4'h_1 : 4'h_0;
      else if (idx_reg == 4'h_1)
      begin
        if (rxByte == telegram_pkg::SYNC_SECOND)
          idx_next = 4'h_2;
        else if (rxByte != telegram_pkg::SYNC_FIRST)
          idx_next = 4'h_0;
        sum_next = 8'h_00;
      end
      else if (idx_reg == telegram_pkg::FRAME_LAST)
      begin
        ok_next   = (rxByte == sum_reg);
        done_next = 1'b1;
        idx_next  = 4'h_0;
      end
      else
      begin
        sum_next = sum_reg + rxByte;
        idx_next = idx_reg + 4'h_1;
        if (idx_reg == 4'h_2)
          hdr_next = rxByte;
        else if (idx_reg == 4'h_3)
          type_next = rxByte;
        else
          data_next = {rxByte, data_reg[71:8]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      idx_reg  <= 4'h_0;
      sum_reg  <= 8'h_00;
      done_reg <= 1'b0;
      hdr_reg  <= 8'h_00;
      type_reg <= 8'h_00;
      data_reg <= 72'h_0;
      ok_reg   <= 1'b0;
    end
    else
    begin
      idx_reg  <= idx_next;
      sum_reg  <= sum_next;
      done_reg <= done_next;
      hdr_reg  <= hdr_next;
      type_reg <= type_next;
      data_reg <= data_next;
      ok_reg   <= ok_next;
    end
  end

  assign frameDone   = done_reg;
  assign frameHeader = hdr_reg;
  assign frameType   = type_reg;
  assign frameData   = data_reg;
  assign frameSumOk  = ok_reg;

endmodule
`default_nettype wire

// ==== rtl/serial_command_interpreter.sv ====
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module serial_command_interpreter
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial byte stream from host
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  // Serial byte stream to host
  output logic [7:0]       txByte,
  output logic             txValid,
  input  wire logic        txReady,
  // Radio side
  output logic             radioSend,
  output logic [71:0]      radioPayload,
  output logic             gainHigh,
  output logic             controllerRestart,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq
);

  typedef enum logic [0:0] {IDLE = 1'b0, SEND = 1'b1} phase_e;

  logic        frameDone;
  logic [7:0]  frameHeader;
  logic [7:0]  frameType;
  logic [71:0] frameData;
  logic        frameSumOk;

  frame_collector collector
  (
    .clk         (clk),
    .reset_n     (reset_n),
    .rxByte      (rxByte),
    .rxValid     (rxValid),
    .frameDone   (frameDone),
    .frameHeader (frameHeader),
    .frameType   (frameType),
    .frameData   (frameData),
    .frameSumOk  (frameSumOk)
  );

  localparam int EV_W = telegram_pkg::EV_WIDTH;

  phase_e      phase_reg, phase_next;
  logic [3:0]  idx_reg, idx_next;
  logic [7:0]  replyType_reg, replyType_next;
  logic [71:0] replyData_reg, replyData_next;
  logic [7:0]  txByte_reg, txByte_next;
  logic        txValid_reg, txValid_next;
  logic [31:0] base_reg, base_next;
  logic [3:0]  count_reg, count_next;
  logic        gain_reg, gain_next;
  logic        restart_reg, restart_next;
  logic        radio_reg, radio_next;
  logic [71:0] payload_reg, payload_next;
  logic [EV_W-1:0] status_reg, status_next;
  logic [EV_W-1:0] mask_reg, mask_next;
  logic        irq_reg, irq_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  logic        take;
  logic [2:0]  seqCode;
  logic [31:0] reqBase;
  logic [31:0] senderId;
  logic [EV_W-1:0] events;
  logic        wbWrite;
  logic [7:0]  replySum;

  assign take     = (phase_reg == IDLE) && frameDone;
  assign seqCode  = frameHeader[7:5];
  assign reqBase  = {frameData[7:0], frameData[15:8], frameData[23:16], frameData[31:24]};
  assign senderId = {frameData[39:32], frameData[47:40], frameData[55:48], frameData[63:56]};
  assign wbWrite  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

  always_comb
  begin
    replySum = telegram_pkg::REPLY_HEADER + replyType_reg;
    for (int i = 0; i < telegram_pkg::DATA_BYTES; i++)
      replySum = replySum + replyData_reg[8*i +: 8];
  end

  // Command decoding and reply framing
  always_comb
  begin
    phase_next     = phase_reg;
    idx_next       = idx_reg;
    replyType_next = replyType_reg;
    replyData_next = replyData_reg;
    base_next      = base_reg;
    count_next     = count_reg;
    gain_next      = gain_reg;
    restart_next   = 1'b0;
    radio_next     = 1'b0;
    payload_next   = payload_reg;
    events         = '0;
    txValid_next   = txValid_reg;
    txByte_next    = txByte_reg;
    if (wbWrite && wb_adr_i == telegram_pkg::OFS_GAIN && wb_sel_i[0])
      gain_next = wb_dat_i[0];
    case (phase_reg)
      IDLE:
      begin
        if (take)
        begin
          phase_next     = SEND;
          replyData_next = '0;
          if (seqCode != telegram_pkg::SEQ_COMMAND && seqCode != telegram_pkg::SEQ_RADIO_TX)
            replyType_next = telegram_pkg::FIELD_SEQUENCE;
          else if (frameHeader[4:0] != telegram_pkg::FRAME_LENGTH)
            replyType_next = telegram_pkg::FIELD_LENGTH;
          else if (!frameSumOk)
            replyType_next = telegram_pkg::FIELD_CHECKSUM;
          else if (seqCode == telegram_pkg::SEQ_RADIO_TX)
          begin
            if (senderId == telegram_pkg::UNIQUE_ID || senderId[31:7] == base_reg[31:7])
            begin
              radio_next     = 1'b1;
              payload_next   = frameData;
              replyType_next = telegram_pkg::REPLY_OK;
            end
            else
              replyType_next = telegram_pkg::transmit_id_reject_reply;
          end
          else
          begin
            case (frameType)
              telegram_pkg::id_base_write_cmd:
              begin
                if (count_reg >= telegram_pkg::REWRITE_LIMIT)
                  replyType_next = telegram_pkg::REPLY_FAIL;
                else if (reqBase < telegram_pkg::BASE_LOW || reqBase > telegram_pkg::BASE_HIGH)
                  replyType_next = telegram_pkg::base_out_of_bounds_reply;
                else
                begin
                  base_next      = {reqBase[31:7], 7'h_00};
                  count_next     = count_reg + 4'h_1;
                  replyType_next = telegram_pkg::REPLY_OK;
                end
              end
              telegram_pkg::id_base_read_cmd:
              begin
                replyType_next       = telegram_pkg::id_base_report;
                replyData_next[31:0] = {base_reg[7:0], base_reg[15:8], base_reg[23:16], base_reg[31:24]};
              end
              telegram_pkg::GAIN_SET_CMD:
              begin
                if (frameData[7:1] == 7'h_00)
                begin
                  gain_next      = frameData[0];
                  replyType_next = telegram_pkg::REPLY_OK;
                end
                else
                  replyType_next = telegram_pkg::REPLY_FAIL;
              end
              telegram_pkg::GAIN_READ_CMD:
              begin
                replyType_next      = telegram_pkg::receiver_gain_report;
                replyData_next[7:0] = {7'h_00, gain_reg};
              end
              telegram_pkg::RESTART_CMD:
              begin
                restart_next = 1'b1;
                phase_next   = IDLE;
              end
              telegram_pkg::firmware_version_read_cmd:
              begin
                replyType_next = telegram_pkg::firmware_version_report;
                replyData_next[63:0] = {telegram_pkg::API_VERSION[7:0], telegram_pkg::API_VERSION[15:8],
                                        telegram_pkg::API_VERSION[23:16], telegram_pkg::API_VERSION[31:24],
                                        telegram_pkg::FW_VERSION[7:0], telegram_pkg::FW_VERSION[15:8],
                                        telegram_pkg::FW_VERSION[23:16], telegram_pkg::FW_VERSION[31:24]};
              end
              default:
                replyType_next = telegram_pkg::FIELD_TYPE;
            endcase
          end
          if (phase_next == SEND)
          begin
            txValid_next = 1'b1;
            txByte_next  = telegram_pkg::SYNC_FIRST;
            idx_next     = 4'h_0;
          end
          else
            events[telegram_pkg::EV_RESTART] = 1'b1;
        end
      end
      SEND:
      begin
        if (txReady)
        begin
          idx_next = idx_reg + 4'h_1;
          case (idx_reg)
            4'h_0:   txByte_next = telegram_pkg::SYNC_SECOND;
            4'h_1:   txByte_next = telegram_pkg::REPLY_HEADER;
            4'h_2:   txByte_next = replyType_reg;
            4'h_C:   txByte_next = replySum;
            4'h_D:   txByte_next = txByte_reg;
            default: txByte_next = replyData_reg[8*(idx_reg-4'h_3) +: 8];
          endcase
          if (idx_reg == telegram_pkg::FRAME_LAST)
          begin
            phase_next   = IDLE;
            txValid_next = 1'b0;
            events[telegram_pkg::EV_REPLY]  = 1'b1;
            events[telegram_pkg::EV_SYNTAX] = replyType_reg[7:2] == 6'h_02;
            events[telegram_pkg::EV_REJECT] = replyType_reg == telegram_pkg::transmit_id_reject_reply;
          end
        end
      end
      default:
        phase_next = IDLE;
    endcase
  end

  // Register bus and interrupt
  always_comb
  begin
    ack_next    = wb_cyc_i && wb_stb_i && !ack_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    rdata_next  = 32'h_0000_0000;
    if (wbWrite && wb_sel_i[0])
    begin
      if (wb_adr_i == telegram_pkg::OFS_STATUS)
        status_next = status_reg & ~wb_dat_i[EV_W-1:0];
      if (wb_adr_i == telegram_pkg::OFS_MASK)
        mask_next = wb_dat_i[EV_W-1:0];
    end
    status_next = status_next | events;
    case (wb_adr_i)
      telegram_pkg::OFS_STATUS: rdata_next = {{(32-EV_W){1'b0}}, status_reg};
      telegram_pkg::OFS_MASK:   rdata_next = {{(32-EV_W){1'b0}}, mask_reg};
      telegram_pkg::OFS_BASE:   rdata_next = base_reg;
      telegram_pkg::OFS_GAIN:   rdata_next = {31'h_0, gain_reg};
      telegram_pkg::OFS_COUNT:  rdata_next = {28'h_0, count_reg};
      default:                  rdata_next = 32'h_0000_0000;
    endcase
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      phase_reg     <= IDLE;
      idx_reg       <= 4'h_0;
      replyType_reg <= 8'h_00;
      replyData_reg <= 72'h_0;
      txByte_reg    <= 8'h_00;
      txValid_reg   <= 1'b0;
      base_reg      <= telegram_pkg::BASE_RESET;
      count_reg     <= 4'h_0;
      gain_reg      <= 1'b1;
      restart_reg   <= 1'b0;
      radio_reg     <= 1'b0;
      payload_reg   <= 72'h_0;
      status_reg    <= '0;
      mask_reg      <= '0;
      irq_reg       <= 1'b0;
      ack_reg       <= 1'b0;
      rdata_reg     <= 32'h_0000_0000;
    end
    else
    begin
      phase_reg     <= phase_next;
      idx_reg       <= idx_next;
      replyType_reg <= replyType_next;
      replyData_reg <= replyData_next;
      txByte_reg    <= txByte_next;
      txValid_reg   <= txValid_next;
      base_reg      <= base_next;
      count_reg     <= count_next;
      gain_reg      <= gain_next;
      restart_reg   <= restart_next;
      radio_reg     <= radio_next;
      payload_reg   <= payload_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      irq_reg       <= irq_next;
      ack_reg       <= ack_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign txByte            = txByte_reg;
  assign txValid           = txValid_reg;
  assign radioSend         = radio_reg;
  assign radioPayload      = payload_reg;
  assign gainHigh          = gain_reg;
  assign controllerRestart = restart_reg;
  assign wb_dat_o          = rdata_reg;
  assign wb_ack_o          = ack_reg;
  assign irq               = irq_reg;

  // Checks
  logic cmdOk;
  assign cmdOk = take && seqCode == telegram_pkg::SEQ_COMMAND && frameSumOk
                 && frameHeader[4:0] == telegram_pkg::FRAME_LENGTH;

  sequence s_replyStart;
    txValid && txByte == telegram_pkg::SYNC_FIRST ##1 phase_reg == SEND;
  endsequence

  property p_limit;
    @(posedge clk) disable iff (!reset_n) count_reg <= telegram_pkg::REWRITE_LIMIT;
  endproperty
  a_limit: assert property (p_limit) else $error("rewrite count above limit");

  property p_range;
    @(posedge clk) disable iff (!reset_n)
      cmdOk && frameType == telegram_pkg::id_base_write_cmd && count_reg < telegram_pkg::REWRITE_LIMIT
      && reqBase < telegram_pkg::BASE_LOW
      |=> replyType_reg == telegram_pkg::base_out_of_bounds_reply && $stable(base_reg);
  endproperty
  a_range: assert property (p_range) else $error("out of range base accepted");

  property p_baseRead;
    @(posedge clk) disable iff (!reset_n)
      cmdOk && frameType == telegram_pkg::id_base_read_cmd
      |=> replyType_reg == telegram_pkg::id_base_report && replyData_reg[7:0] == base_reg[31:24];
  endproperty
  a_baseRead: assert property (p_baseRead) else $error("bad base report");

  property p_gainSet;
    @(posedge clk) disable iff (!reset_n)
      cmdOk && frameType == telegram_pkg::GAIN_SET_CMD && frameData[7:0] == 8'h_01
      |=> gainHigh && replyType_reg == telegram_pkg::REPLY_OK ##0 s_replyStart;
  endproperty
  a_gainSet: assert property (p_gainSet) else $error("gain set not applied");

  property p_restart;
    @(posedge clk) disable iff (!reset_n)
      cmdOk && frameType == telegram_pkg::RESTART_CMD |=> controllerRestart && !txValid ##1 !controllerRestart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart misbehaved");

  property p_version;
    @(posedge clk) disable iff (!reset_n)
      cmdOk && frameType == telegram_pkg::firmware_version_read_cmd
      |=> replyType_reg == telegram_pkg::firmware_version_report ##0 s_replyStart;
  endproperty
  a_version: assert property (p_version) else $error("no version report");

  property p_checksum;
    @(posedge clk) disable iff (!reset_n)
      take && !frameSumOk && seqCode == telegram_pkg::SEQ_COMMAND && frameHeader[4:0] == telegram_pkg::FRAME_LENGTH
      |=> replyType_reg == telegram_pkg::FIELD_CHECKSUM;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum error not reported");

  property p_txReject;
    @(posedge clk) disable iff (!reset_n)
      radioSend |-> $past(senderId[31:7]) == base_reg[31:7] || $past(senderId) == telegram_pkg::UNIQUE_ID;
  endproperty
  a_txReject: assert property (p_txReject) else $error("radio send outside range");

endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  // Clock
  input  wire logic       clk,
  // Command bytes to the block
  output logic [7:0]      rxByte,
  output logic            rxValid,
  // Reply bytes from the block
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady
);
  logic [7:0] rep [14];
  bit         slow = 0;
  initial
  begin
    rxByte = 8'h_00;
    rxValid = 1'b0;
    txReady = 1'b0;
  end
  task automatic send(input logic [7:0] h, t, input logic [71:0] d, input logic [7:0] bad);
    logic [7:0] s;
    s = h + t + bad;
    for (int i = 0; i < 9; i++)
      s += d[i*8+:8];
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxByte  <= i == 0 ? 8'h_A5 : i == 1 ? 8'h_5A : i == 2 ? h : i == 3 ? t : i == 13 ? s : d[(i-4)*8+:8];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte  <= ~rxByte;
  endtask
  task automatic receive(output int n);
    n = 0;
    for (int k = 0; k < 300 && n < 14; k++)
    begin
      @(negedge clk);
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
        rep[n] = txByte;
        n++;
      end
      @(posedge clk);
      txReady <= n < 14 && (slow ? !txReady : 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/serial_command_interpreter_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module serial_command_interpreter_test;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h_00;
  logic [31:0] wdat = 32'h_0000_0000;
  logic [31:0] rdat, datO;
  logic [7:0]  rxByte, txByte;
  logic        ack, rxValid, txValid, txReady, radioSend, gainHigh, restart, irq;
  logic [71:0] payload;
  logic [7:0]  r [14];
  int          errors = 0;
  int          samples_checked = 0;
  int          sends = 0;
  int          restarts = 0;
  int          cycles = 0;
  initial forever #20 clk = ~clk;
  serial_command_interpreter i_serial_command_interpreter (.clk(clk), .reset_n(reset_n), .rxByte(rxByte),
    .rxValid(rxValid), .txByte(txByte), .txValid(txValid), .txReady(txReady), .radioSend(radioSend),
    .radioPayload(payload), .gainHigh(gainHigh), .controllerRestart(restart), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h_F), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .irq(irq));
  host_model i_host_model (.clk(clk), .rxByte(rxByte), .rxValid(rxValid), .txByte(txByte), .txValid(txValid),
    .txReady(txReady));
  always @(negedge clk)
  begin
    cycles++;
    sends += radioSend === 1'b1;
    restarts += restart === 1'b1;
    if (cycles == 20000)
      end_sim(1);
  end
  task automatic end_sim(input int hung);
    errors += hung;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = datO;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] h, t, input logic [71:0] d, input logic [7:0] bad, input int len);
    int n;
    logic [7:0] s;
    i_host_model.send(h, t, d, bad);
    i_host_model.receive(n);
    r = i_host_model.rep;
    s = 8'h_00;
    for (int i = 2; i < 13; i++)
      s += r[i];
    check(n, len, "reply size");
    if (n == 14)
    begin
      check({r[0], r[1], r[2]}, 24'h_A5_5A8B, "reply head");
      check(r[13], s, "reply sum");
    end
  endtask
  task automatic t_base;
    logic [31:0] v;
    for (int i = 0; i < 13; i++)
    begin
      v = i == 0 ? 32'h_FF7F_FF80 : i == 1 ? 32'h_FFFF_FFFF : i == 2 ? 32'h_FFFF_FFFE : 32'h_FF80_0015 + (i - 3) * 128;
      cmd(8'h_AB, 8'h_18, {40'h_0, {<<8{v}}}, 8'h_00, 14);
      check(r[3], i < 2 ? 8'h_1A : i < 12 ? 8'h_58 : 8'h_19, "rewrite");
    end
    wb(0, telegram_pkg::OFS_COUNT, 0);
    check(rdat, 10, "count");
    cmd(8'h_AB, telegram_pkg::id_base_read_cmd, 0, 8'h_00, 14);
    check(r[3], 8'h_98, "base report");
    check({r[4], r[5], r[6], r[7]}, 32'h_FF80_0400, "base");
    $display("base test done");
  endtask
  task automatic t_gain;
    for (int g = 0; g < 2; g++)
    begin
      cmd(8'h_AB, 8'h_08, 72'(g), 8'h_00, 14);
      check(r[3], 8'h_58, "gain ok");
      check(gainHigh, g[0], "gain pin");
      cmd(8'h_AB, 8'h_48, 0, 8'h_00, 14);
      check({r[3], r[4]}, {8'h_88, 8'(g)}, "gain report");
    end
    cmd(8'h_AB, 8'h_08, 72'h_02, 8'h_00, 14);
    check(r[3], 8'h_19, "gain bad value");
    check(gainHigh, 1, "gain kept");
    $display("gain test done");
  endtask
  task automatic t_version;
    i_host_model.slow = 1;
    cmd(8'h_AB, 8'h_4B, 0, 8'h_00, 14);
    check(r[3], 8'h_8C, "version type");
    check({r[4], r[5], r[6], r[7]}, telegram_pkg::FW_VERSION, "fw");
    check({r[8], r[9], r[10], r[11]}, telegram_pkg::API_VERSION, "api");
    i_host_model.slow = 0;
    $display("version test done");
  endtask
  task automatic t_syntax;
    // Header, type, checksum offset, field code
    logic [31:0] c [4] = '{32'h_2B4B_0008, 32'h_AC4B_0009, 32'h_AB4B_010A, 32'h_AB77_000B};
    for (int i = 0; i < 4; i++)
    begin
      cmd(c[i][31:24], c[i][23:16], 0, c[i][15:8], 14);
      check(r[3], c[i][7:0], "syntax field");
    end
    $display("syntax test done");
  endtask
  task automatic t_radio;
    logic [31:0] id [3] = '{telegram_pkg::UNIQUE_ID, 32'h_FF80_047F, 32'h_FF80_0480};
    logic [71:0] d;
    int s0;
    for (int i = 0; i < 3; i++)
    begin
      d = {8'h_5C, {<<8{id[i]}}, 32'h_1122_3344};
      s0 = sends;
      cmd(8'h_6B, 8'h_F6, d, 8'h_00, 14);
      check(r[3], i < 2 ? 8'h_58 : 8'h_22, "radio reply");
      check(sends - s0, i < 2, "radio sent");
      if (i < 2)
      begin
        check(payload[39:8], d[39:8], "payload");
        check(payload[71:40], d[71:40], "payload top");
      end
    end
    $display("radio test done");
  endtask
  task automatic t_irq;
    wb(0, telegram_pkg::OFS_STATUS, 0);
    check(rdat[3:0], 4'h_7, "status");
    check(irq, 0, "masked");
    wb(1, telegram_pkg::OFS_MASK, 4);
    @(negedge clk);
    check(irq, 1, "unmasked");
    wb(1, telegram_pkg::OFS_STATUS, 4);
    @(negedge clk);
    check(irq, 0, "cleared");
    wb(1, telegram_pkg::OFS_BASE, 0);
    wb(0, telegram_pkg::OFS_BASE, 0);
    check(rdat, 32'h_FF80_0400, "base read only");
    wb(0, 5'h_14, 0);
    check(rdat, 0, "unmapped");
    wb(1, telegram_pkg::OFS_GAIN, 0);
    check(gainHigh, 0, "gain by bus");
    wb(0, telegram_pkg::OFS_GAIN, 0);
    check(rdat, 0, "gain read");
    $display("irq test done");
  endtask
  task automatic t_restart;
    int s0;
    s0 = restarts;
    cmd(8'h_AB, 8'h_0A, 0, 8'h_00, 0);
    check(restarts - s0, 1, "restart pulse");
    wb(0, telegram_pkg::OFS_STATUS, 0);
    check(rdat[3], 1, "restart event");
    $display("restart test done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_base;
    t_gain;
    t_version;
    t_syntax;
    t_radio;
    t_irq;
    t_restart;
    end_sim(0);
  end
endmodule
`default_nettype wire
